/* File: src/cpl_top.sv */
`timescale 1ns/10ps
`include "cpl_cfg.svh"
// What this block does
// - Load chosen profile when reset ends
// - Profile from pin or bit, source bit
// - Two independent factory profiles held
// - Host may write registers after reset
// - Written values lost, profile reloaded at reset
// - Two-bit field picks one of three modes
// - Mode follows field in either profile
// - Divider even values 10 to 2046
// - Divider code LSB ignored
// - Divider stage same in every mode
// - Monitor inputs, raise alarm bit and pin
// - Manual, revertive, non-revertive switching
// - Synth uses upper loop, fractional feedback
// - Pin low profile zero, high profile one
module cpl_top (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // I2C port
  input  wire logic              scl,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe,
  input  wire logic [1:0]        i2c_addr_pins,
  // Selection pins
  input  wire logic              cfg_pin,
  input  wire logic              ref_pick_pin,
  // Monitored clocks
  input  wire logic              xtal_clk,
  input  wire logic              ref0_clk,
  input  wire logic              ref1_clk,
  input  wire logic              fb_upper,
  input  wire logic              fb_lower,
  // Alarm and status pins
  output logic                   xtal_bad,
  output logic                   ref0_bad,
  output logic                   ref1_bad,
  output logic                   holdover,
  output logic                   ref_active,
  output logic                   irq,
  // Decoded operating controls
  output cpl_pkg::cpl_mode_t     mode,
  output logic                   lower_loop_en,
  output logic                   frac_fb_en,
  output logic [12:0]            frac_code,
  output logic [10:0]            divide_ratio,
  output logic                   divide_ok,
  output logic                   profile_active
);
  import cpl_pkg::*;

  localparam int NS = 11; // Synchronised inputs

  logic [NS-1:0] async_in;  // Raw pins
  logic [NS-1:0] sync_in;   // After two flops
  logic [NS-1:0] sync_q;    // Previous synced value
  logic [NS-1:0] rise;      // Synced rising edges
  logic [7:0]    ctrl;      // Mode, policy, pick
  logic [10:0]   ndiv;      // output_divide_code
  logic [12:0]   frac;      // Fractional feedback
  logic [1:0]    cfg;       // [0] profile bit, [1] source
  logic [4:0]    stat;      // Sticky events
  logic [4:0]    mask;      // Interrupt enables
  logic [2:0]    bad;       // xtal, ref0, ref1
  logic [1:0]    rb;        // Reference alarms
  logic [31:0]   rom_q;     // Profile word
  cpl_ld_t       ld_st;     // Loader state
  logic          ld_sel;    // Profile being fetched
  logic          prof_sel;  // Governing selection
  logic          prof_cur;  // Loaded profile
  cpl_pol_t      pol;       // Switching policy

  // Every input but clock, reset and AXI goes through the synchroniser
  assign async_in = {scl, sda_i, i2c_addr_pins, cfg_pin, ref_pick_pin,
                     xtal_clk, ref0_clk, ref1_clk, fb_upper, fb_lower};

  cpl_sync #(.W(NS)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (async_in),
    .q       (sync_in)
  );

  // Previous value for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_q <= '0;
    end else begin
      sync_q <= sync_in;
    end
  end
  assign rise = sync_in & ~sync_q;

  // Mode decode, reserved code behaves as low bandwidth
  function automatic cpl_mode_t mode_of(input logic [1:0] c);
    mode_of = (c == 2'h1) ? CPL_HBW : (c == 2'h2) ? CPL_SYN : CPL_LBW;
  endfunction : mode_of

  // Byte-lane merge for AXI writes
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  s);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
    end
  endfunction : merge

  // ---------------- Profile selection and load
  assign prof_sel = cfg[1] ? cfg[0] : sync_in[6];

  cpl_profile_rom u_rom (
    .aclk (aclk),
    .sel  (prof_sel),
    .q    (rom_q)
  );

  // Loader: fetch after reset and whenever the selection moves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ld_st    <= CPL_LD_FETCH;
      ld_sel   <= 1'b0;
      prof_cur <= 1'b0;
    end else begin
      unique case (ld_st)
        CPL_LD_IDLE: begin
          if (prof_sel != prof_cur) begin
            ld_st <= CPL_LD_FETCH;
          end
        end
        CPL_LD_FETCH: begin
          ld_sel <= prof_sel;
          ld_st  <= CPL_LD_WRITE;
        end
        CPL_LD_WRITE: begin
          prof_cur <= ld_sel;
          ld_st    <= CPL_LD_IDLE;
        end
      endcase
    end
  end

  // ---------------- AXI4-Lite slave
  logic        aw_ok, w_ok, axi_we;
  logic [7:0]  wa;
  logic [31:0] wd;
  logic [3:0]  ws;
  logic [31:0] rd_word;
  logic        rd_ok;

  assign awready = !aw_ok && !bvalid;
  assign wready  = !w_ok && !bvalid;
  assign arready = !rvalid;
  assign axi_we  = aw_ok && w_ok && !bvalid;

  // Address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok <= 1'b0;
      w_ok  <= 1'b0;
      wa    <= 8'h00;
      wd    <= 32'h0000_0000;
      ws    <= 4'h0;
    end else if (axi_we) begin
      aw_ok <= 1'b0;
      w_ok  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_ok <= 1'b1;
        wa    <= awaddr;
      end
      if (wvalid && wready) begin
        w_ok <= 1'b1;
        wd   <= wdata;
        ws   <= wstrb;
      end
    end
  end

  // Write response one cycle after the write happens
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= `CPL_RESP_OK;
    end else if (axi_we) begin
      bvalid <= 1'b1;
      bresp  <= (wa <= `CPL_OFF_LIVE && wa[1:0] == 2'h0) ?
                `CPL_RESP_OK : `CPL_RESP_ERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read mux, unmapped words read zero with an error
  always_comb begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    case (araddr)
      `CPL_OFF_CTRL: rd_word = {24'h000000, ctrl};
      `CPL_OFF_NDIV: rd_word = {21'h000000, ndiv};
      `CPL_OFF_FRAC: rd_word = {19'h00000, frac};
      `CPL_OFF_CFG:  rd_word = {30'h00000000, cfg};
      `CPL_OFF_STAT: rd_word = {27'h0000000, stat};
      `CPL_OFF_MASK: rd_word = {27'h0000000, mask};
      `CPL_OFF_LIVE: rd_word = {25'h0000000, divide_ok, prof_cur,
                                ref_active, holdover, bad};
      default:       rd_ok   = 1'b0;
    endcase
  end

  // Read data held until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `CPL_RESP_OK;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_word;
      rresp  <= rd_ok ? `CPL_RESP_OK : `CPL_RESP_ERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ---------------- I2C write receiver, sampled by aclk
  logic       scl_s, sda_s, scl_q, sda_q, i_act, i2c_we;
  logic [3:0] i_bit;
  logic [7:0] i_sh, i_ptr;
  cpl_iph_t   i_ph;

  assign scl_s  = sync_in[10];
  assign sda_s  = sync_in[9];
  assign scl_q  = sync_q[10];
  assign sda_q  = sync_q[9];
  assign sda_o  = 1'b0; // Open drain, only ever pulls low
  assign i2c_we = i_act && scl_q && !scl_s && i_bit == 4'h8
                  && i_ph == CPL_IP_DATA;

  // Start, stop, bit shifting and acknowledge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      i_act  <= 1'b0;
      i_ph   <= CPL_IP_ADDR;
      i_bit  <= 4'h0;
      i_sh   <= 8'h00;
      i_ptr  <= 8'h00;
      sda_oe <= 1'b0;
    end else if (scl_s && scl_q && sda_q && !sda_s) begin
      i_act  <= 1'b1;
      i_ph   <= CPL_IP_ADDR;
      i_bit  <= 4'h0;
      sda_oe <= 1'b0;
    end else if (scl_s && scl_q && !sda_q && sda_s) begin
      i_act  <= 1'b0;
      sda_oe <= 1'b0;
    end else if (i_act && rise[10] && i_bit < 4'h8) begin
      i_sh  <= {i_sh[6:0], sda_s};
      i_bit <= i_bit + 4'h1;
    end else if (i_act && scl_q && !scl_s && i_bit == 4'h8) begin
      i_bit  <= 4'h9;
      sda_oe <= 1'b1;
      unique case (i_ph)
        CPL_IP_ADDR: begin
          // Reads and foreign addresses get no acknowledge
          if (i_sh != {`CPL_I2C_BASE, sync_in[8:7], 1'b0}) begin
            i_act  <= 1'b0;
            sda_oe <= 1'b0;
          end else begin
            i_ph <= CPL_IP_PTR;
          end
        end
        CPL_IP_PTR: begin
          i_ptr <= i_sh;
          i_ph  <= CPL_IP_DATA;
        end
        CPL_IP_DATA: i_ptr <= i_ptr + 8'h01;
      endcase
    end else if (i_act && scl_q && !scl_s && i_bit == 4'h9) begin
      i_bit  <= 4'h0;
      sda_oe <= 1'b0;
    end
  end

  // Lane-merged write words; a call result cannot be part-selected
  logic [31:0] wm_ctrl; // Control word after strobes
  logic [31:0] wm_ndiv; // Divider word after strobes
  logic [31:0] wm_frac; // Fraction word after strobes
  assign wm_ctrl = merge({24'h000000, ctrl}, wd, ws);
  assign wm_ndiv = merge({21'h000000, ndiv}, wd, ws);
  assign wm_frac = merge({19'h00000, frac}, wd, ws);

  // ---------------- Operating registers
  // Load beats both hosts; AXI beats I2C in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `CPL_RST_CTRL;
      ndiv <= `CPL_RST_NDIV;
      frac <= `CPL_RST_FRAC;
    end else if (ld_st == CPL_LD_WRITE) begin
      ctrl <= rom_q[`CPL_P_CTRL];
      ndiv <= rom_q[`CPL_P_NDIV];
      frac <= rom_q[`CPL_P_FRAC];
    end else begin
      if (i2c_we) begin
        case (i_ptr)
          `CPL_PTR_CTRL: ctrl <= i_sh;
          `CPL_PTR_NDLO: ndiv[7:0] <= i_sh;
          `CPL_PTR_NDHI: ndiv[10:8] <= i_sh[2:0];
          `CPL_PTR_FRLO: frac[7:0] <= i_sh;
          `CPL_PTR_FRHI: frac[12:8] <= i_sh[4:0];
          default: ;
        endcase
      end
      if (axi_we) begin
        case (wa)
          `CPL_OFF_CTRL: ctrl <= wm_ctrl[7:0];
          `CPL_OFF_NDIV: ndiv <= wm_ndiv[10:0];
          `CPL_OFF_FRAC: frac <= wm_frac[12:0];
          default: ;
        endcase
      end
    end
  end

  // Profile source bits and interrupt enables; never touched by a profile load
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg  <= `CPL_RST_CFG;
      mask <= 5'h00;
    end else begin
      if (i2c_we && i_ptr == `CPL_PTR_CFG) begin
        cfg <= i_sh[1:0];
      end
      if (axi_we && wa == `CPL_OFF_CFG && ws[0]) begin
        cfg <= wd[1:0];
      end
      if (axi_we && wa == `CPL_OFF_MASK && ws[0]) begin
        mask <= wd[4:0];
      end
    end
  end

  // ---------------- Decoded outputs, same divider in all modes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode           <= CPL_LBW;
      lower_loop_en  <= 1'b1;
      frac_fb_en     <= 1'b0;
      frac_code      <= `CPL_RST_FRAC;
      divide_ratio   <= `CPL_RST_NDIV;
      divide_ok      <= 1'b1;
      profile_active <= 1'b0;
    end else begin
      mode           <= mode_of(ctrl[`CPL_F_MODE]);
      lower_loop_en  <= mode_of(ctrl[`CPL_F_MODE]) == CPL_LBW;
      frac_fb_en     <= mode_of(ctrl[`CPL_F_MODE]) == CPL_SYN;
      frac_code      <= frac;
      divide_ratio   <= {ndiv[10:1], 1'b0};
      divide_ok      <= ndiv >= `CPL_NDIV_MIN;
      profile_active <= prof_cur;
    end
  end

  // ---------------- Clock monitors: three feedback edges, no input
  logic [1:0] mon_cnt [3];
  for (genvar i = 0; i < 3; i++) begin : g_mon
    logic fb_edge; // Feedback edge for this monitor
    assign fb_edge = (i == 0 || mode != CPL_LBW) ? rise[1] : rise[0];
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        mon_cnt[i] <= 2'h0;
        bad[i]     <= 1'b0;
      end else if (rise[4-i]) begin
        mon_cnt[i] <= 2'h0;
        bad[i]     <= 1'b0;
      end else if (fb_edge && mon_cnt[i] != `CPL_ALARM_EDGES) begin
        mon_cnt[i] <= mon_cnt[i] + 2'h1;
        bad[i]     <= mon_cnt[i] == `CPL_ALARM_EDGES - 2'h1;
      end
    end
  end
  assign xtal_bad = bad[0];
  assign ref0_bad = bad[1];
  assign ref1_bad = bad[2];
  assign rb       = bad[2:1];

  // ---------------- Reference switching
  assign pol = cpl_pol_t'(ctrl[`CPL_F_POL]);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_active <= 1'b0;
      holdover   <= 1'b0;
    end else begin
      unique case (pol)
        CPL_MAN_PIN:  ref_active <= sync_in[5];
        CPL_MAN_REG:  ref_active <= ctrl[`CPL_F_PICK];
        CPL_AUTO_REV: begin
          if (!rb[ctrl[`CPL_F_PICK]]) begin
            ref_active <= ctrl[`CPL_F_PICK];
          end else if (!rb[!ctrl[`CPL_F_PICK]]) begin
            ref_active <= !ctrl[`CPL_F_PICK];
          end
        end
        CPL_AUTO_NREV: begin
          if (rb[ref_active] && !rb[!ref_active]) begin
            ref_active <= !ref_active;
          end
        end
      endcase
      // Manual holds over when the chosen input fails
      holdover <= (pol == CPL_MAN_PIN) ? rb[sync_in[5]] :
                  (pol == CPL_MAN_REG) ? rb[ctrl[`CPL_F_PICK]] : &rb;
    end
  end

  // ---------------- Sticky status and interrupt
  logic [2:0] bad_q;  // Alarm history for edges
  logic       hold_q;
  logic [4:0] ev;     // Events this cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bad_q  <= 3'h0;
      hold_q <= 1'b0;
    end else begin
      bad_q  <= bad;
      hold_q <= holdover;
    end
  end
  assign ev = {holdover & ~hold_q, ld_st == CPL_LD_WRITE, bad & ~bad_q};

  // Set beats a write-one clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat <= 5'h00;
    end else if (axi_we && wa == `CPL_OFF_STAT && ws[0]) begin
      stat <= (stat & ~wd[4:0]) | ev;
    end else begin
      stat <= stat | ev;
    end
  end
  assign irq = |(stat & mask);

  // ---------------- Checks
  a_reset_load: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |=> ld_st == CPL_LD_WRITE)
    else $error("profile not loaded after reset");
  a_sel_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    (ld_st == CPL_LD_IDLE && prof_sel != prof_cur) |=>
    ld_st == CPL_LD_FETCH ##1 ld_st == CPL_LD_WRITE)
    else $error("selection change did not reload");
  a_load_word: assert property (@(posedge aclk) disable iff (!aresetn)
    ld_st == CPL_LD_WRITE |=> ndiv == $past(rom_q[`CPL_P_NDIV]))
    else $error("divider not taken from profile");
  a_host_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (axi_we && wa == `CPL_OFF_NDIV && ws[1:0] == 2'h3 &&
     ld_st != CPL_LD_WRITE) |=> ndiv == $past(wd[10:0]))
    else $error("host divider write lost");
  a_mode_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 mode == mode_of($past(ctrl[1:0])))
    else $error("mode does not follow field");
  a_div_even: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 divide_ratio == {$past(ndiv[10:1]), 1'b0})
    else $error("divider ratio wrong");
  a_div_range: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 divide_ok == ($past(ndiv) >= `CPL_NDIV_MIN))
    else $error("divider range flag wrong");
  a_alarm_edges: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(bad[0]) |-> $past(mon_cnt[0]) == 2'h2 && mon_cnt[0] == 2'h3)
    else $error("crystal alarm without three edges");
  a_synth_upper: assert property (@(posedge aclk) disable iff (!aresetn)
    mode == CPL_SYN |-> !lower_loop_en && frac_fb_en)
    else $error("synth mode uses lower loop");
  a_event_sticky: assert property (@(posedge aclk)
    disable iff (!aresetn)
    ev[`CPL_S_LOAD] |=> stat[`CPL_S_LOAD] ##1
    (stat[`CPL_S_LOAD] || $past(axi_we && wa == `CPL_OFF_STAT && ws[0] &&
                                wd[`CPL_S_LOAD])))
    else $error("load event not held");
  c_reload: cover property (@(posedge aclk) disable iff (!aresetn)
    ld_st == CPL_LD_IDLE ##1 ld_st == CPL_LD_FETCH);
  c_i2c_write: cover property (@(posedge aclk) disable iff (!aresetn)
    i2c_we);
  c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
endmodule : cpl_top

/* File: src/cpl_cfg.svh */
`ifndef CPL_CFG_SVH
`define CPL_CFG_SVH

// Register byte offsets on the AXI4-Lite slave
`define CPL_OFF_CTRL 8'h00
`define CPL_OFF_NDIV 8'h04
`define CPL_OFF_FRAC 8'h08
`define CPL_OFF_CFG  8'h0C
`define CPL_OFF_STAT 8'h10
`define CPL_OFF_MASK 8'h14
`define CPL_OFF_LIVE 8'h18

// Byte pointers seen from the I2C port
`define CPL_PTR_CTRL  8'h00
`define CPL_PTR_NDLO  8'h01
`define CPL_PTR_NDHI  8'h02
`define CPL_PTR_FRLO  8'h03
`define CPL_PTR_FRHI  8'h04
`define CPL_PTR_CFG   8'h05

// Field positions in the control byte and in a profile word
`define CPL_F_MODE 1:0
`define CPL_F_POL  3:2
`define CPL_F_PICK 4
`define CPL_P_CTRL 7:0
`define CPL_P_NDIV 18:8
`define CPL_P_FRAC 31:19

// Status bit positions
`define CPL_S_LOAD 3
`define CPL_S_HOLD 4

// Reset values of the operating registers
`define CPL_RST_CTRL 8'h00
`define CPL_RST_NDIV 11'h00A
`define CPL_RST_FRAC 13'h0000
`define CPL_RST_CFG  2'h0

// Factory profiles, arbitrary defaults
`define CPL_PROF0 32'h0000_1008
`define CPL_PROF1 32'h0800_0C02

// Divider limit and alarm edge count
`define CPL_NDIV_MIN 11'h00A
`define CPL_ALARM_EDGES 2'h3

// Upper I2C address bits, arbitrary value
`define CPL_I2C_BASE 5'h1B

// AXI responses
`define CPL_RESP_OK  2'h0
`define CPL_RESP_ERR 2'h2

`endif

/* File: src/cpl_pkg.sv */
package cpl_pkg;
  // Operating mode decoded from the two-bit field
  typedef enum logic [1:0] {
    CPL_LBW,
    CPL_HBW,
    CPL_SYN
  } cpl_mode_t;

  // Reference switching policy
  typedef enum logic [1:0] {
    CPL_MAN_PIN,
    CPL_MAN_REG,
    CPL_AUTO_REV,
    CPL_AUTO_NREV
  } cpl_pol_t;

  // Profile loader states
  typedef enum logic [1:0] {
    CPL_LD_IDLE,
    CPL_LD_FETCH,
    CPL_LD_WRITE
  } cpl_ld_t;

  // I2C byte phase
  typedef enum logic [1:0] {
    CPL_IP_ADDR,
    CPL_IP_PTR,
    CPL_IP_DATA
  } cpl_iph_t;
endpackage : cpl_pkg

/* File: src/cpl_sync.sv */
`timescale 1ns/10ps
// Two-flop synchroniser for every asynchronous input
module cpl_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Raw and synchronised levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta; // First stage, read only by q

  // One flop pair per bit
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        meta[i] <= 1'b0;
        q[i]    <= 1'b0;
      end else begin
        meta[i] <= d[i];
        q[i]    <= meta[i];
      end
    end
  end
endmodule : cpl_sync

/* File: src/cpl_profile_rom.sv */
`timescale 1ns/10ps
`include "cpl_cfg.svh"
// Two factory profiles with registered read data
module cpl_profile_rom (
  // Clock
  input  wire logic        aclk,
  // Profile index and word
  input  wire logic        sel,
  output logic      [31:0] q
);
  // Fixed contents, one word per profile
  localparam logic [31:0] PROF [2] = '{`CPL_PROF0, `CPL_PROF1};

  // Read every cycle; the loader samples q one cycle later
  always_ff @(posedge aclk) begin
    q <= PROF[sel];
  end
endmodule : cpl_profile_rom

/* File: dv/cpl_i2c_host.sv */
`timescale 1ns/10ps
// Behavioural I2C host; clock idles high between frames
module cpl_i2c_host (
  // Line levels
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Data moves mid low phase, line read mid high
  task automatic bit_io(input logic b, output logic s);
    sda_pull = !b;
    #100 scl = 1'b1;
    #100 s = sda;
    #100 scl = 1'b0;
    #100;
  endtask : bit_io

  // Byte MSB first, then the acknowledge slot
  task automatic byte_io(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask : byte_io

  // Address, pointer and one data byte
  task automatic put(input logic [6:0] dev, input logic [7:0] ptr,
                     input logic [7:0] d, output logic [2:0] ack);
    sda_pull = 1'b1; // Start with clock high
    #200 scl = 1'b0;
    #100;
    byte_io({dev, 1'b0}, ack[2]);
    byte_io(ptr, ack[1]);
    byte_io(d, ack[0]);
    sda_pull = 1'b1;
    #100 scl = 1'b1;
    #200 sda_pull = 1'b0;
    #400; // Idle gap for downstream restart
  endtask : put
endmodule : cpl_i2c_host

/* File: dv/tb_clock_profile_config_loader.sv */
`timescale 1ns/10ps
`include "cpl_cfg.svh"
// Register, pin and link scenarios
module tb_clock_profile_config_loader;
  import cpl_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata;
  logic        cfg_pin, fb, xtal_clk, ref0_clk, ref1_clk;
  logic [2:0]  src_on, acks;
  logic [3:0]  cnt = 4'h0;
  logic [10:0] divide_ratio;
  logic        lower_loop_en, frac_fb_en, divide_ok, profile_active;
  logic        ref0_bad, ref1_bad, xtal_bad, irq, holdover, ref_active;
  logic [12:0] frac_code;
  cpl_mode_t   mode;
  wire         awready, wready, bvalid, arready, rvalid, sda_oe, sda_o;
  wire         scl, sda_pull, sda_w;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  logic [10:0] codes [4] = '{11'h00B, 11'h009, 11'h7FF, 11'h00A};
  int          err_count, checks_done;

  cpl_top dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .scl,
    .sda_i(sda_w), .sda_o, .sda_oe, .i2c_addr_pins(2'h1), .cfg_pin,
    .ref_pick_pin(1'b0), .xtal_clk, .ref0_clk, .ref1_clk, .fb_upper(fb),
    .fb_lower(fb), .xtal_bad, .ref0_bad, .ref1_bad, .holdover,
    .ref_active, .irq, .mode, .lower_loop_en, .frac_fb_en,
    .frac_code, .divide_ratio, .divide_ok, .profile_active);
  cpl_i2c_host host_u (.scl, .sda_pull, .sda(sda_w));
  // Pulled-up line, low when either side pulls
  assign sda_w = !(sda_pull | (sda_oe & !sda_o));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // Inputs toggle faster than feedback, so no alarm while on
  always @(posedge aclk) begin
    cnt <= cnt + 4'h1;
    fb <= cnt[2];
    {ref1_clk, ref0_clk, xtal_clk} <= src_on & {3{cnt[1]}};
  end

  task automatic summarize;
    if (err_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %0t seen %h want %h", $time, s, e);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : settle

  // Write: both channels offered together, bready held
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = `CPL_RESP_OK);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        done = 1'b1;
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, r});
      end
    end
    if (!done) begin
      err_count++;
      summarize();
    end
  endtask : wr

  // Read and compare data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r = `CPL_RESP_OK);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        done = 1'b1;
        rready <= 1'b0;
        chk({30'h0, rresp}, {30'h0, r});
        chk(rdata, e);
      end
    end
    if (!done) begin
      err_count++;
      summarize();
    end
  endtask : rd

  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    settle(4);
  endtask : do_reset

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    cfg_pin = 1'b0;
    src_on = 3'h7;
    do_reset();
    rd(`CPL_OFF_CTRL, 32'h08);
    rd(`CPL_OFF_NDIV, 32'h10);
    rd(`CPL_OFF_CFG, 32'h0);
    rd(`CPL_OFF_STAT, 32'h08);
    chk({31'h0, profile_active}, 32'h0);
    cfg_pin <= 1'b1;
    settle(10);
    rd(`CPL_OFF_CTRL, 32'h02);
    chk({29'h0, mode, frac_fb_en}, 32'h5);
    chk({31'h0, lower_loop_en}, 32'h0);
    chk({21'h0, divide_ratio}, 32'hC);
    chk({18'h0, profile_active, frac_code}, 32'h2100);
    wr(`CPL_OFF_CFG, 32'h2);
    settle(6);
    rd(`CPL_OFF_CTRL, 32'h08);
    wr(`CPL_OFF_CFG, 32'h3);
    settle(6);
    rd(`CPL_OFF_CTRL, 32'h02);
    for (int m = 0; m < 4; m++) begin
      wr(`CPL_OFF_CTRL, m);
      settle(2);
      chk({30'h0, mode}, (m == 3) ? 0 : m);
      chk({31'h0, lower_loop_en}, m % 3 == 0);
    end
    foreach (codes[i]) begin
      wr(`CPL_OFF_NDIV, {21'h0, codes[i]});
      settle(2);
      chk({20'h0, divide_ok, divide_ratio},
          {20'h0, codes[i] >= 11'h00A, codes[i] & 11'h7FE});
    end
    host_u.put({`CPL_I2C_BASE, 2'h1}, `CPL_PTR_CTRL, 8'h01, acks);
    chk({29'h0, acks}, 32'h7);
    rd(`CPL_OFF_CTRL, 32'h01);
    chk({30'h0, mode}, 32'h1);
    host_u.put({`CPL_I2C_BASE, 2'h1}, `CPL_PTR_NDLO, 8'h0D, acks);
    settle(2);
    chk({21'h0, divide_ratio}, 32'hC);
    host_u.put({`CPL_I2C_BASE, 2'h2}, `CPL_PTR_CTRL, 8'h02, acks);
    chk({29'h0, acks}, 32'h0);
    rd(`CPL_OFF_CTRL, 32'h01);
    wr(`CPL_OFF_STAT, 32'h1F);
    src_on <= 3'h5;
    settle(40);
    chk({29'h0, ref1_bad, ref0_bad, xtal_bad}, 32'h2);
    chk({31'h0, irq}, 32'h0);
    wr(`CPL_OFF_MASK, 32'h02);
    settle(1);
    chk({31'h0, irq}, 32'h1);
    chk({30'h0, holdover, ref_active}, 32'h2);
    rd(`CPL_OFF_LIVE, 32'h6A);
    wr(`CPL_OFF_CTRL, 32'h08);
    settle(2);
    chk({30'h0, holdover, ref_active}, 32'h1);
    src_on <= 3'h7;
    settle(20);
    chk({31'h0, ref0_bad}, 32'h0);
    chk({30'h0, holdover, ref_active}, 32'h0);
    wr(`CPL_OFF_CTRL, 32'h14);
    settle(2);
    chk({30'h0, holdover, ref_active}, 32'h1);
    wr(`CPL_OFF_CTRL, 32'h0C);
    settle(2);
    chk({30'h0, holdover, ref_active}, 32'h1);
    wr(`CPL_OFF_STAT, 32'h02);
    settle(1);
    chk({31'h0, irq}, 32'h0);
    rd(8'h1C, 32'h0, `CPL_RESP_ERR);
    wr(8'h1C, 32'h0, `CPL_RESP_ERR);
    do_reset();
    settle(10);
    rd(`CPL_OFF_CTRL, 32'h02);
    rd(`CPL_OFF_NDIV, 32'h0C);
    rd(`CPL_OFF_CFG, 32'h0);
    summarize();
  end
endmodule : tb_clock_profile_config_loader
